// ---- hw/switch_pkg.sv ----
// Constants, register map and state codes for the light switch block
package switch_pkg;
   localparam int CLK_PERIOD_NS = 25;
   // Evaluation cycle of the timebase: 1 ms
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_OFF_DLY  = 8'h04;
   localparam logic [7:0] ADDR_HOLD     = 8'h08;
   localparam logic [7:0] ADDR_WARN_LD  = 8'h0C;
   localparam logic [7:0] ADDR_WARN_LEN = 8'h10;
   localparam logic [7:0] ADDR_TIMEBASE = 8'h14;
   localparam logic [7:0] ADDR_STATUS   = 8'h18;

   localparam int CTRL_WARN_EN_BIT = 0;
   localparam int CTRL_RETAIN_BIT  = 1;
   localparam int STAT_OUT_BIT     = 0;
   localparam int STAT_STATE_LSB   = 4;
   localparam int STAT_ELAPSED_LSB = 16;

   localparam logic [1:0]  RST_CTRL     = 2'h0;
   localparam logic [15:0] RST_OFF_DLY  = 16'h00B4;
   localparam logic [15:0] RST_HOLD     = 16'h0064;
   localparam logic [15:0] RST_WARN_LD  = 16'h000F;
   localparam logic [15:0] RST_WARN_LEN = 16'h0001;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [3:0] {
      ST_OFF   = 4'h1,
      ST_HOLD  = 4'h2,
      ST_TIMED = 4'h4,
      ST_PERM  = 4'h8
   } state_t;
endpackage : switch_pkg

// ---- hw/tick_if.sv ----
// Timebase carrier between the switch core and its tick generator
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic [15:0] period;
   logic        tick;
   modport gen (input period, output tick);
   modport use_side (output period, input tick);
endinterface : tick_if
`default_nettype wire

// ---- hw/sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : sync2
`default_nettype wire

// ---- hw/tick_gen.sv ----
// Evaluation cycle tick from the configured timebase
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
   input  wire logic hclk,
   input  wire logic hresetn,
   tick_if.gen       tb
);
   logic [15:0] cnt_reg;
   logic        last;

   // A period of zero behaves as one so the tick never stops
   assign last = (cnt_reg + 16'h0001 >= tb.period);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 16'h0000;
      end else if (last) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign tb.tick = last;
endmodule : tick_gen
`default_nettype wire

// ---- hw/light_switch.sv ----
// Multi-function light switch with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RQ1) A rising trigger switches the output on.
// (RQ2) Trigger held for the hold time from off latches permanent on.
// (RQ3) Trigger released before hold time starts off-delay from zero.
// (RQ4) Output goes off when elapsed time reaches the off-delay.
// (RQ5) Optional warning: output low for warning length before expiry.
// (RQ6) New trigger while on clears elapsed time and switches off.
// (RQ7) Clear input zeroes elapsed time and switches output off.
// (RQ8) Power loss clears state unless retention is enabled.
// (RQ9) Software gives all times in one common timebase.
// (RQ10) Inputs sampled and time advanced once per timebase tick; power is sampled every clock.
// (RQ11) Clear wins over trigger in the same tick.
module light_switch #(
   parameter logic [15:0] TICK_CYCLES_DFLT = 16'(switch_pkg::TICK_CYCLES)
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp,
   input  wire logic        trigger_in,
   input  wire logic        clear_in,
   input  wire logic        power_good_in,
   output var  logic        switch_out
);
   logic                 wr_pend_reg;
   logic [7:0]           wr_addr_reg;
   logic                 warn_en_reg;
   logic                 retain_reg;
   logic [15:0]          off_dly_reg;
   logic [15:0]          hold_reg;
   logic [15:0]          warn_ld_reg;
   logic [15:0]          warn_len_reg;
   logic [15:0]          timebase_reg;
   logic [2:0]           pins_s;
   logic                 trg_s;
   logic                 clr_s;
   logic                 pwr_s;
   logic                 pwr_prev_reg;
   logic                 trg_prev_reg;
   logic                 tick;
   logic                 rise;
   logic                 pwr_restore;
   logic                 addr_ok;
   switch_pkg::state_t   state_reg;
   switch_pkg::state_t   state_next;
   logic [15:0]          elapsed_reg;
   logic [15:0]          elapsed_next;
   logic                 out_next;
   logic [16:0]          elapsed_inc;

   tick_if tb ();

   sync2 #(.WIDTH(3)) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({power_good_in, clear_in, trigger_in}),
      .sync_out (pins_s)
   );

   // (RQ10) single tick enable
   assign tb.period = timebase_reg;
   tick_gen u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tb      (tb)
   );
   assign tick = tb.tick;

   assign trg_s = pins_s[0];
   assign clr_s = pins_s[1];
   assign pwr_s = pins_s[2];

   // Bus slave: zero wait states, always OKAY, word accesses only
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel && hready && (htrans == switch_pkg::HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // Writes land in the data phase; unmapped offsets are ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warn_en_reg  <= switch_pkg::RST_CTRL[switch_pkg::CTRL_WARN_EN_BIT];
         retain_reg   <= switch_pkg::RST_CTRL[switch_pkg::CTRL_RETAIN_BIT];
         off_dly_reg  <= switch_pkg::RST_OFF_DLY;
         hold_reg     <= switch_pkg::RST_HOLD;
         warn_ld_reg  <= switch_pkg::RST_WARN_LD;
         warn_len_reg <= switch_pkg::RST_WARN_LEN;
         timebase_reg <= TICK_CYCLES_DFLT;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == switch_pkg::ADDR_CTRL) begin
            warn_en_reg <= hwdata[switch_pkg::CTRL_WARN_EN_BIT];
            retain_reg  <= hwdata[switch_pkg::CTRL_RETAIN_BIT];
         end else if (wr_addr_reg == switch_pkg::ADDR_OFF_DLY) begin
            off_dly_reg <= hwdata[15:0];
         end else if (wr_addr_reg == switch_pkg::ADDR_HOLD) begin
            hold_reg <= hwdata[15:0];
         end else if (wr_addr_reg == switch_pkg::ADDR_WARN_LD) begin
            warn_ld_reg <= hwdata[15:0];
         end else if (wr_addr_reg == switch_pkg::ADDR_WARN_LEN) begin
            warn_len_reg <= hwdata[15:0];
         end else if (wr_addr_reg == switch_pkg::ADDR_TIMEBASE) begin
            timebase_reg <= hwdata[15:0];
         end
      end
   end

   // Read data is latched at the address phase, so a read right behind
   // a write to the same register returns the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         if (haddr[7:0] == switch_pkg::ADDR_CTRL) begin
            hrdata <= {30'h0000_0000, retain_reg, warn_en_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_OFF_DLY) begin
            hrdata <= {16'h0000, off_dly_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_HOLD) begin
            hrdata <= {16'h0000, hold_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_WARN_LD) begin
            hrdata <= {16'h0000, warn_ld_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_WARN_LEN) begin
            hrdata <= {16'h0000, warn_len_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_TIMEBASE) begin
            hrdata <= {16'h0000, timebase_reg};
         end else if (haddr[7:0] == switch_pkg::ADDR_STATUS) begin
            hrdata <= {elapsed_reg, 8'h00, state_reg, 3'h0, switch_out};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // Warning window: [off - lead, off - lead + len)
   function automatic logic in_warn(input logic [15:0] el);
      logic [16:0] start;
      start = {1'b0, off_dly_reg} - {1'b0, warn_ld_reg};
      in_warn = warn_en_reg && (warn_ld_reg <= off_dly_reg) &&
                ({1'b0, el} >= start) &&
                ({1'b0, el} < start + {1'b0, warn_len_reg});
   endfunction : in_warn

   // (RQ10) trigger sampled once per tick, power sampled every clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trg_prev_reg <= 1'b0;
         pwr_prev_reg <= 1'b0;
      end else begin
         pwr_prev_reg <= pwr_s;
         if (tick && pwr_s) begin
            trg_prev_reg <= trg_s;
         end
      end
   end

   assign rise        = trg_s && !trg_prev_reg;
   assign pwr_restore = pwr_s && !pwr_prev_reg;
   assign elapsed_inc = {1'b0, elapsed_reg} + 17'h0_0001;

   always_comb begin
      state_next   = state_reg;
      elapsed_next = elapsed_reg;
      // (RQ8) power restore clears
      if (pwr_restore && !retain_reg) begin
         state_next   = switch_pkg::ST_OFF;
         elapsed_next = 16'h0000;
      end else if (tick && pwr_s) begin
         // (RQ7) (RQ11) clear first
         if (clr_s) begin
            state_next   = switch_pkg::ST_OFF;
            elapsed_next = 16'h0000;
         end else begin
            case (state_reg)
               switch_pkg::ST_OFF: begin
                  // (RQ1) switch on
                  if (rise) begin
                     state_next   = switch_pkg::ST_HOLD;
                     elapsed_next = 16'h0000;
                  end
               end
               switch_pkg::ST_HOLD: begin
                  if (trg_s) begin
                     // (RQ2) latch permanent
                     if (elapsed_inc >= {1'b0, hold_reg}) begin
                        state_next   = switch_pkg::ST_PERM;
                        elapsed_next = 16'h0000;
                     end else begin
                        elapsed_next = elapsed_inc[15:0];
                     end
                  end else begin
                     // (RQ3) start off-delay
                     state_next   = switch_pkg::ST_TIMED;
                     elapsed_next = 16'h0000;
                  end
               end
               switch_pkg::ST_TIMED: begin
                  if (rise) begin
                     // (RQ6) retrigger switches off
                     state_next   = switch_pkg::ST_OFF;
                     elapsed_next = 16'h0000;
                  end else if (elapsed_inc >= {1'b0, off_dly_reg}) begin
                     // (RQ4) off-delay expired
                     state_next   = switch_pkg::ST_OFF;
                     elapsed_next = off_dly_reg;
                  end else begin
                     elapsed_next = elapsed_inc[15:0];
                  end
               end
               switch_pkg::ST_PERM: begin
                  // (RQ6) retrigger switches off
                  if (rise) begin
                     state_next   = switch_pkg::ST_OFF;
                     elapsed_next = 16'h0000;
                  end
               end
               default: begin
                  state_next   = switch_pkg::ST_OFF;
                  elapsed_next = 16'h0000;
               end
            endcase
         end
      end
   end

   // Process form, so edits to the warning registers re-evaluate it
   // (RQ5) warning blink
   always_comb begin
      out_next = pwr_s && ((state_next == switch_pkg::ST_HOLD) ||
                 (state_next == switch_pkg::ST_PERM) ||
                 ((state_next == switch_pkg::ST_TIMED) &&
                  !in_warn(elapsed_next)));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg   <= switch_pkg::ST_OFF;
         elapsed_reg <= 16'h0000;
      end else begin
         state_reg   <= state_next;
         elapsed_reg <= elapsed_next;
      end
   end

   // Output held low while power is down; state is kept, and survives restore only with retain_reg set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         switch_out <= 1'b0;
      end else begin
         switch_out <= out_next;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic base_ok;
   assign base_ok = tick && pwr_s && !(pwr_restore && !retain_reg);

   rise_on_a: assert property ( // RQ1
      base_ok && !clr_s && state_reg == switch_pkg::ST_OFF && rise
      |=> state_reg == switch_pkg::ST_HOLD && switch_out)
      else $error("trigger edge did not switch on");
   perm_latch_a: assert property ( // RQ2
      base_ok && !clr_s && state_reg == switch_pkg::ST_HOLD && trg_s &&
      elapsed_inc >= {1'b0, hold_reg}
      |=> state_reg == switch_pkg::ST_PERM && elapsed_reg == 16'h0000)
      else $error("long press did not latch");
   delay_start_a: assert property ( // RQ3
      base_ok && !clr_s && state_reg == switch_pkg::ST_HOLD && !trg_s
      |=> state_reg == switch_pkg::ST_TIMED && elapsed_reg == 16'h0000)
      else $error("off-delay not started");
   delay_expire_a: assert property ( // RQ4
      base_ok && !clr_s && !rise && state_reg == switch_pkg::ST_TIMED &&
      elapsed_inc >= {1'b0, off_dly_reg}
      |=> !switch_out && state_reg == switch_pkg::ST_OFF)
      else $error("output not off at expiry");
   warn_low_a: assert property ( // RQ5
      state_reg == switch_pkg::ST_TIMED && $past(pwr_s) &&
      in_warn(elapsed_reg) && $stable(state_reg) |-> !switch_out)
      else $error("output high inside warning");
   retrig_off_a: assert property ( // RQ6
      base_ok && !clr_s && rise && (state_reg == switch_pkg::ST_TIMED ||
      state_reg == switch_pkg::ST_PERM)
      |=> !switch_out && elapsed_reg == 16'h0000)
      else $error("retrigger did not switch off");
   clear_off_a: assert property ( // RQ7
      base_ok && clr_s
      |=> !switch_out && elapsed_reg == 16'h0000 &&
          state_reg == switch_pkg::ST_OFF)
      else $error("clear did not switch off");
   power_clear_a: assert property ( // RQ8
      pwr_restore && !retain_reg
      |=> state_reg == switch_pkg::ST_OFF && elapsed_reg == 16'h0000)
      else $error("state kept without retention");
   tick_spacing_a: assert property ( // RQ10
      tick && timebase_reg > 16'h0001
      |=> ($stable(timebase_reg) |-> !tick))
      else $error("ticks too close");
   clear_prio_a: assert property ( // RQ11
      base_ok && clr_s && rise |=> state_reg == switch_pkg::ST_OFF)
      else $error("trigger beat clear");

   perm_seen_c: cover property (state_reg == switch_pkg::ST_PERM);
   warn_seen_c: cover property (
      state_reg == switch_pkg::ST_TIMED && in_warn(elapsed_reg));
   expire_seen_c: cover property (
      state_reg == switch_pkg::ST_TIMED ##1 state_reg == switch_pkg::ST_OFF);
endmodule : light_switch
`default_nettype wire

// ---- sim/trigger_src.sv ----
// Far-side model: program logic pulsing the switch request pin
`timescale 1ns/1ps
`default_nettype none
module trigger_src (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        press_req,
   input  wire logic [15:0] press_len,
   output var  logic        trigger_in
);
   logic [15:0] hold_cnt_reg;
   // Level held for the whole press, so short and long presses share one path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_cnt_reg <= 16'h0000;
         trigger_in   <= 1'b0;
      end else if (press_req) begin
         hold_cnt_reg <= press_len;
         trigger_in   <= 1'b1;
      end else if (hold_cnt_reg > 16'h0001) begin
         hold_cnt_reg <= hold_cnt_reg - 16'h0001;
      end else begin
         hold_cnt_reg <= 16'h0000;
         trigger_in   <= 1'b0;
      end
   end
endmodule : trigger_src
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the light switch block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] T_DLY   = 16'h0014;
   localparam logic [15:0] T_HLD   = 16'h000A;
   localparam logic [15:0] T_LD    = 16'h0005;
   localparam logic [15:0] T_LEN   = 16'h0002;
   localparam logic [15:0] TB_DFLT = 16'h0004;
   logic        hclk          = 1'b0;
   logic        hresetn       = 1'b0;
   logic        hsel          = 1'b0;
   logic [31:0] haddr         = 32'h0000_0000;
   logic [1:0]  htrans        = 2'h0;
   logic        hwrite        = 1'b0;
   logic [2:0]  hsize         = 3'h2;
   logic [31:0] hwdata        = 32'h0000_0000;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        trigger_in;
   logic        clear_in      = 1'b0;
   logic        power_good_in = 1'b1;
   logic        switch_out;
   logic        press_req     = 1'b0;
   logic [15:0] press_len     = 16'h0000;
   logic [31:0] q;
   int          err_total     = 0;
   int          comparisons   = 0;

   always #12.5 hclk = ~hclk;

   light_switch #(.TICK_CYCLES_DFLT(TB_DFLT)) light_switch_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .trigger_in(trigger_in), .clear_in(clear_in),
      .power_good_in(power_good_in), .switch_out(switch_out));

   trigger_src trigger_src_i (
      .hclk(hclk), .hresetn(hresetn), .press_req(press_req),
      .press_len(press_len), .trigger_in(trigger_in));

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: %s", $time, msg);
         err_total++;
      end
   endtask : check

   // Waits for hready at each phase; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= switch_pkg::HTRANS_NONSEQ;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      check({31'h0, hresp}, 32'h0000_0000, "bus response");
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(q, exp, "register read");
   endtask : rd

   task automatic stat(input logic [3:0] st, input logic [15:0] el);
      bus(1'b0, switch_pkg::ADDR_STATUS, 32'h0000_0000);
      check({12'h000, q[31:16], q[7:4]}, {12'h000, el, st}, "status");
   endtask : stat

   task automatic press(input logic [15:0] len);
      @(posedge hclk);
      press_req <= 1'b1;
      press_len <= len;
      @(posedge hclk);
      press_req <= 1'b0;
   endtask : press

   task automatic wait_out(input logic lvl, input int max, output int n);
      n = 0;
      while (switch_out !== lvl && n < max) begin
         @(negedge hclk);
         n++;
      end
      check(32'(n < max), 32'h0000_0001, "output level not reached");
   endtask : wait_out

   task automatic in_range(input int n, input int lo, input int hi);
      check(32'(n >= lo && n <= hi), 32'h0000_0001, "span out of range");
   endtask : in_range

   task automatic t_regs;
      rd(switch_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(switch_pkg::ADDR_OFF_DLY, 32'h0000_00B4);
      rd(switch_pkg::ADDR_HOLD, 32'h0000_0064);
      rd(switch_pkg::ADDR_WARN_LD, 32'h0000_000F);
      rd(switch_pkg::ADDR_WARN_LEN, 32'h0000_0001);
      rd(switch_pkg::ADDR_TIMEBASE, {16'h0000, TB_DFLT});
      rd(8'h1C, 32'h0000_0000);
      // Status is read-only, so this write must leave it alone
      bus(1'b1, switch_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      rd(switch_pkg::ADDR_STATUS, 32'h0000_0010);
      bus(1'b1, switch_pkg::ADDR_OFF_DLY, {16'h0000, T_DLY});
      bus(1'b1, switch_pkg::ADDR_HOLD, {16'h0000, T_HLD});
      bus(1'b1, switch_pkg::ADDR_WARN_LD, {16'h0000, T_LD});
      bus(1'b1, switch_pkg::ADDR_WARN_LEN, {16'h0000, T_LEN});
      bus(1'b1, switch_pkg::ADDR_TIMEBASE, 32'h0000_0001);
      rd(switch_pkg::ADDR_OFF_DLY, {16'h0000, T_DLY});
      $display("registers test done");
   endtask : t_regs

   task automatic t_short;
      int n;
      press(16'h0003);
      wait_out(1'b1, 8, n);
      wait_out(1'b0, 60, n);
      in_range(n, T_DLY, T_DLY + 6);
      stat(switch_pkg::ST_OFF, T_DLY);
      $display("short press test done");
   endtask : t_short

   task automatic t_warn;
      int n;
      bus(1'b1, switch_pkg::ADDR_CTRL, 32'h0000_0001);
      press(16'h0003);
      wait_out(1'b1, 8, n);
      wait_out(1'b0, 60, n);
      in_range(n, T_DLY - T_LD, T_DLY - T_LD + 6);
      wait_out(1'b1, 20, n);
      check(32'(n), {16'h0000, T_LEN}, "warning length");
      wait_out(1'b0, 20, n);
      in_range(n, T_LD - T_LEN - 1, T_LD - T_LEN + 1);
      bus(1'b1, switch_pkg::ADDR_CTRL, 32'h0000_0000);
      $display("warning test done");
   endtask : t_warn

   task automatic t_perm;
      int n;
      press(T_HLD + 16'h0005);
      wait_out(1'b1, 8, n);
      repeat (2 * T_DLY) @(negedge hclk);
      check({31'h0, switch_out}, 32'h0000_0001, "permanent on");
      stat(switch_pkg::ST_PERM, 16'h0000);
      press(16'h0003);
      wait_out(1'b0, 8, n);
      stat(switch_pkg::ST_OFF, 16'h0000);
      // Retrigger while the off-delay runs
      press(16'h0003);
      wait_out(1'b1, 8, n);
      repeat (6) @(negedge hclk);
      press(16'h0003);
      wait_out(1'b0, 8, n);
      repeat (10) @(negedge hclk);
      check({31'h0, switch_out}, 32'h0000_0000, "stays off");
      stat(switch_pkg::ST_OFF, 16'h0000);
      $display("permanent and retrigger test done");
   endtask : t_perm

   task automatic t_clear;
      int n;
      press(16'h0003);
      wait_out(1'b1, 8, n);
      @(posedge hclk);
      clear_in <= 1'b1;
      wait_out(1'b0, 8, n);
      stat(switch_pkg::ST_OFF, 16'h0000);
      press(16'h0003);
      repeat (10) @(negedge hclk);
      check({31'h0, switch_out}, 32'h0000_0000, "clear wins");
      @(posedge hclk);
      clear_in <= 1'b0;
      repeat (6) @(negedge hclk);
      check({31'h0, switch_out}, 32'h0000_0000, "no late edge");
      $display("clear test done");
   endtask : t_clear

   task automatic t_power;
      int n;
      press(16'h0003);
      wait_out(1'b1, 8, n);
      @(posedge hclk);
      power_good_in <= 1'b0;
      wait_out(1'b0, 6, n);
      @(posedge hclk);
      power_good_in <= 1'b1;
      repeat (8) @(negedge hclk);
      check({31'h0, switch_out}, 32'h0000_0000, "not restored");
      stat(switch_pkg::ST_OFF, 16'h0000);
      bus(1'b1, switch_pkg::ADDR_CTRL, 32'h0000_0002);
      press(T_HLD + 16'h0005);
      wait_out(1'b1, 8, n);
      repeat (2 * T_HLD) @(negedge hclk);
      @(posedge hclk);
      power_good_in <= 1'b0;
      wait_out(1'b0, 6, n);
      @(posedge hclk);
      power_good_in <= 1'b1;
      wait_out(1'b1, 10, n);
      stat(switch_pkg::ST_PERM, 16'h0000);
      press(16'h0003);
      wait_out(1'b0, 8, n);
      // Power loss mid off-delay: elapsed time must freeze and come back
      repeat (8) @(negedge hclk);
      press(16'h0003);
      wait_out(1'b1, 8, n);
      repeat (8) @(negedge hclk);
      @(posedge hclk);
      power_good_in <= 1'b0;
      wait_out(1'b0, 6, n);
      stat(switch_pkg::ST_TIMED, 16'h0008);
      @(posedge hclk);
      power_good_in <= 1'b1;
      wait_out(1'b1, 10, n);
      stat(switch_pkg::ST_TIMED, 16'h000A);
      wait_out(1'b0, 30, n);
      bus(1'b1, switch_pkg::ADDR_CTRL, 32'h0000_0000);
      $display("power test done");
   endtask : t_power

   task automatic t_tick;
      int n;
      bus(1'b1, switch_pkg::ADDR_TIMEBASE, 32'h0000_0004);
      press(16'h000C);
      wait_out(1'b1, 20, n);
      wait_out(1'b0, 4 * T_DLY + 40, n);
      in_range(n, 4 * T_DLY, 4 * T_DLY + 24);
      bus(1'b1, switch_pkg::ADDR_TIMEBASE, 32'h0000_0001);
      $display("timebase test done");
   endtask : t_tick

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // Let the power-restore seen after reset settle first
      repeat (6) @(posedge hclk);
      t_regs();
      t_short();
      t_warn();
      t_perm();
      t_clear();
      t_power();
      t_tick();
      summarize();
   end

   // Whole run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
